// File: egc_group.sv
// Purpose: One canceller group: coding mode decode, power state and init sequencer.
// Assumes: Control byte comes from the register bank on the same clock.
// Notes: The init sequencer walks 64 register slots, then waits until two frames have passed since the walk began.
`default_nettype none
module egc_group #(
  parameter int unsigned INIT_CYCLES = egc_pkg::INIT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [7:0] ctrl,
  output logic init_busy,
  output logic init_done,
  output logic clear_we,
  output logic [5:0] clear_addr,
  output logic powered,
  output logic [1:0] coding
);
  typedef enum logic [2:0] {
    EGC_IDLE = 3'b001,
    EGC_WIPE = 3'b010,
    EGC_WAIT = 3'b100
  } egc_gst_t;
  typedef struct packed {
    egc_gst_t st;
    logic pwr_prev;
    logic [17:0] cnt;
    logic done;
  } egc_gstate_t;
  egc_gstate_t s_q, s_d;
  logic pwr;
  assign pwr = ctrl[egc_pkg::CTRL_POWER_BIT];
  // Sequencer: a rising power bit starts preset and coefficient wipe.
  always_comb begin
    s_d = s_q;
    s_d.pwr_prev = pwr;
    s_d.done = 1'b0;
    unique case (s_q.st)
      EGC_IDLE: begin
        if (pwr && !s_q.pwr_prev) begin
          s_d.st = EGC_WIPE;
          s_d.cnt = 18'h00000;
        end
      end
      EGC_WIPE: begin
        s_d.cnt = s_q.cnt + 18'h00001;
        if (s_q.cnt[5:0] == 6'h3F) begin
          s_d.st = EGC_WAIT;
        end
      end
      EGC_WAIT: begin
        s_d.cnt = s_q.cnt + 18'h00001;
        if (s_q.cnt >= 18'(INIT_CYCLES - 1)) begin
          s_d.st = EGC_IDLE;
          s_d.done = 1'b1;
        end
      end
      default: s_d.st = EGC_IDLE;
    endcase
    if (!pwr) begin
      s_d.st = EGC_IDLE; // Dropping power aborts the routine.
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{st: EGC_IDLE, pwr_prev: 1'b0, cnt: 18'h00000, done: 1'b0};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end
  assign init_busy = (s_q.st != EGC_IDLE);
  assign init_done = s_q.done;
  assign clear_we = (s_q.st == EGC_WIPE);
  assign clear_addr = s_q.cnt[5:0];
  // The cycle in which the power bit rises is not yet running: init starts on the next edge.
  assign powered = pwr && s_q.pwr_prev && (s_q.st == EGC_IDLE);
  // Coding: 00 sign-magnitude, 10 mu-law, 11 A-law.
  assign coding = {ctrl[egc_pkg::CTRL_CODING_BIT],
                   ctrl[egc_pkg::CTRL_CODING_BIT] & ctrl[egc_pkg::CTRL_LAW_BIT]};
endmodule : egc_group
`default_nettype wire

// File: egc_pkg.sv
// Purpose: Shared constants for the echo group control and interrupt queue block.
// Assumes: 8-bit register port, 50 MHz ref_clk, four canceller groups.
// Notes: Offsets are byte addresses on the plain register port.
`default_nettype none
package egc_pkg;
  localparam int unsigned NUM_GROUPS = 4;
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned QUEUE_DEPTH = 16;
  // Register offsets.
  localparam logic [10:0] GROUP_CTRL_BASE = 11'h400;
  localparam logic [10:0] IRQ_QUEUE_ADDR = 11'h410;
  localparam logic [10:0] IRQ_STATUS_ADDR = 11'h411;
  localparam logic [10:0] IRQ_MASK_ADDR = 11'h412;
  localparam logic [10:0] INIT_STATUS_ADDR = 11'h413;
  // Per-channel register window of one canceller pair.
  localparam logic [10:0] CHAN_REG_SPAN = 11'h040;
  // Control register fields.
  localparam int unsigned CTRL_CODING_BIT = 3;
  localparam int unsigned CTRL_LAW_BIT = 2;
  localparam int unsigned CTRL_POWER_BIT = 0;
  localparam int unsigned CTRL_MASK_A_BIT = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Interrupt queue register fields.
  localparam int unsigned QUEUE_PEND_BIT = 7;
  localparam logic [7:0] QUEUE_RESET = 8'h00;
  // Status bits: 0 tone event queued, 1 queue overflow, 2 init done.
  localparam int unsigned EV_TONE = 0;
  localparam int unsigned EV_OVF = 1;
  localparam int unsigned EV_INIT = 2;
  localparam logic [2:0] EV_RESET = 3'h0;
  // Initialization lasts two PCM frames of 125 us each.
  localparam int unsigned FRAME_NS = 125000;
  localparam int unsigned CLK_NS = 20;
  localparam int unsigned INIT_FRAMES = 2;
  localparam int unsigned INIT_CYCLES = (INIT_FRAMES * FRAME_NS + CLK_NS - 1) / CLK_NS;
endpackage : egc_pkg
`default_nettype wire

// File: egc_top.sv
// Purpose: Group control registers, init sequencers and tone interrupt queue.
// Assumes: Register port is synchronous to ref_clk; tone events come from on-chip logic.
// Notes: Queue entries are popped by reads of the queue register.
`default_nettype none
module egc_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [10:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic tone_evt,
  input wire logic [4:0] tone_chan,
  input wire logic [31:0] rin_pcm,
  output var logic [7:0] reg_rdata,
  output var logic irq,
  output var logic [3:0] group_powered,
  output var logic [7:0] group_coding,
  output var logic [3:0] init_busy,
  output var logic [3:0] clear_we,
  output var logic [23:0] clear_addr,
  output var logic [31:0] rout_bypass,
  output var logic [3:0] bypass_en
);
  localparam int unsigned NG = egc_pkg::NUM_GROUPS;
  localparam int unsigned QD = egc_pkg::QUEUE_DEPTH;

  typedef struct packed {
    logic [NG-1:0][7:0] ctrl;
    logic [QD-1:0][4:0] q;
    logic [3:0] wp;
    logic [3:0] rp;
    logic [4:0] cnt;
    logic [2:0] stat;
    logic [2:0] mask;
    logic [7:0] rdata;
    logic irq;
    logic [NG-1:0] pwr;
    logic [NG-1:0][1:0] coding;
    logic [NG-1:0] busy;
    logic [NG-1:0] cwe;
    logic [NG-1:0][5:0] caddr;
    logic [31:0] rout;
    logic [NG-1:0] byp;
  } egc_state_t;

  egc_state_t s_q, s_d;
  logic [NG-1:0] g_busy, g_done, g_cwe, g_pwr;
  logic [NG-1:0][5:0] g_caddr;
  logic [NG-1:0][1:0] g_coding;

  // Decode used for writes and reads of the group control registers.
  function automatic logic [2:0] grp_sel(input logic [10:0] a);
    logic [10:0] off;
    off = a - egc_pkg::GROUP_CTRL_BASE;
    if (a >= egc_pkg::GROUP_CTRL_BASE && off < 11'(NG)) begin
      grp_sel = {1'b1, off[1:0]};
    end else begin
      grp_sel = 3'h0;
    end
  endfunction : grp_sel

  // One sequencer per group; each keeps its own two-frame init timer.
  genvar gi;
  generate
    for (gi = 0; gi < NG; gi++) begin : g_grp
      egc_group u_grp (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .ctrl(s_q.ctrl[gi]),
        .init_busy(g_busy[gi]),
        .init_done(g_done[gi]),
        .clear_we(g_cwe[gi]),
        .clear_addr(g_caddr[gi]),
        .powered(g_pwr[gi]),
        .coding(g_coding[gi])
      );
    end
  endgenerate

  logic [2:0] wsel, rsel;
  assign wsel = grp_sel(reg_addr);
  assign rsel = grp_sel(reg_addr);

  // Next state: register writes, queue push and pop, status and read data.
  always_comb begin
    logic push, pop, full;
    logic [2:0] ev, clr;
    s_d = s_q;
    full = (s_q.cnt == 5'(QD));
    push = tone_evt && !full;
    pop = reg_rd && (reg_addr == egc_pkg::IRQ_QUEUE_ADDR) && (s_q.cnt != 5'h00);
    ev = 3'h0;
    clr = 3'h0;
    ev[egc_pkg::EV_TONE] = push;
    ev[egc_pkg::EV_OVF] = tone_evt && full;
    ev[egc_pkg::EV_INIT] = |g_done;
    if (reg_wr && wsel[2]) begin
      s_d.ctrl[wsel[1:0]] = reg_wdata;
    end
    if (reg_wr && reg_addr == egc_pkg::IRQ_MASK_ADDR) begin
      s_d.mask = reg_wdata[2:0];
    end
    // Reads of the queue register only pop; writes there are ignored.
    if (push) begin
      s_d.q[s_q.wp] = tone_chan;
      s_d.wp = s_q.wp + 4'h1;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 4'h1;
    end
    s_d.cnt = s_q.cnt + 5'(push) - 5'(pop);
    s_d.rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr == egc_pkg::IRQ_QUEUE_ADDR) begin
        if (s_q.cnt != 5'h00) begin
          s_d.rdata = {1'b1, 2'b00, s_q.q[s_q.rp]};
        end
      end else if (reg_addr == egc_pkg::IRQ_STATUS_ADDR) begin
        s_d.rdata = {5'h00, s_q.stat};
        clr = s_q.stat;
      end else if (reg_addr == egc_pkg::IRQ_MASK_ADDR) begin
        s_d.rdata = {5'h00, s_q.mask};
      end else if (reg_addr == egc_pkg::INIT_STATUS_ADDR) begin
        s_d.rdata = {4'h0, g_busy};
      end else if (rsel[2]) begin
        s_d.rdata = s_q.ctrl[rsel[1:0]];
      end
    end
    // A new event beats a clear made by the same read.
    s_d.stat = (s_q.stat & ~clr) | ev;
    s_d.irq = |(s_d.stat & s_d.mask);
    s_d.pwr = g_pwr;
    s_d.coding = g_coding;
    s_d.busy = g_busy;
    s_d.cwe = g_cwe;
    s_d.caddr = g_caddr;
    // Powered-down groups pass receive PCM straight through.
    for (int g = 0; g < NG; g++) begin
      s_d.byp[g] = !s_q.ctrl[g][egc_pkg::CTRL_POWER_BIT];
      s_d.rout[g*8 +: 8] = rin_pcm[g*8 +: 8];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.byp <= '1;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign irq = s_q.irq;
  assign group_powered = s_q.pwr;
  assign group_coding = s_q.coding;
  assign init_busy = s_q.busy;
  assign clear_we = s_q.cwe;
  assign clear_addr = s_q.caddr;
  assign rout_bypass = s_q.rout;
  assign bypass_en = s_q.byp;

  property p_queue_zero_when_empty;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && reg_rd && reg_addr == egc_pkg::IRQ_QUEUE_ADDR && s_q.cnt == 5'h00)
        |=> (reg_rdata == 8'h00);
  endproperty
  a_queue_zero_when_empty: assert property (p_queue_zero_when_empty)
    else $error("Empty queue read not zero.");

  property p_queue_pending_bit;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && reg_rd && reg_addr == egc_pkg::IRQ_QUEUE_ADDR && s_q.cnt != 5'h00)
        |=> (reg_rdata[7] && reg_rdata[6:5] == 2'b00);
  endproperty
  a_queue_pending_bit: assert property (p_queue_pending_bit)
    else $error("Queue entry lacks pending flag.");

  property p_bypass_when_down;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && !s_q.ctrl[0][egc_pkg::CTRL_POWER_BIT]) |=> bypass_en[0];
  endproperty
  a_bypass_when_down: assert property (p_bypass_when_down)
    else $error("Group 0 down but not bypassed.");

  property p_init_starts;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && $rose(s_q.ctrl[0][egc_pkg::CTRL_POWER_BIT])) ##1 clk_en |=> init_busy[0];
  endproperty
  a_init_starts: assert property (p_init_starts)
    else $error("Init did not start on power rise.");

  property p_coding_alaw;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && s_q.ctrl[1][egc_pkg::CTRL_CODING_BIT] && s_q.ctrl[1][egc_pkg::CTRL_LAW_BIT])
        |=> (group_coding[3:2] == 2'b11 || !clk_en);
  endproperty
  a_coding_alaw: assert property (p_coding_alaw)
    else $error("A-law not selected.");

  // An accepted tone event must leave its sticky status bit set.
  property p_tone_sets_status;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && tone_evt && s_q.cnt != 5'(QD)) |=> s_q.stat[egc_pkg::EV_TONE];
  endproperty
  a_tone_sets_status: assert property (p_tone_sets_status)
    else $error("Tone event did not set status.");

  // A full queue drops the event and reports the loss instead.
  property p_queue_overflow;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && tone_evt && !reg_rd && s_q.cnt == 5'(QD))
        |=> (s_q.stat[egc_pkg::EV_OVF] && s_q.cnt == 5'(QD));
  endproperty
  a_queue_overflow: assert property (p_queue_overflow)
    else $error("Overflow not reported or entry count changed.");

  // Reading a non-empty queue removes exactly one entry.
  property p_queue_pop;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && reg_rd && reg_addr == egc_pkg::IRQ_QUEUE_ADDR && s_q.cnt != 5'h00 && !tone_evt)
        |=> (s_q.cnt == $past(s_q.cnt) - 5'h01);
  endproperty
  a_queue_pop: assert property (p_queue_pop)
    else $error("Queue read did not pop one entry.");

  // The preset walk must begin at the first slot of the window.
  property p_init_first_slot;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(init_busy[0]) |-> (clear_we[0] && clear_addr[5:0] == 6'h00);
  endproperty
  a_init_first_slot: assert property (p_init_first_slot)
    else $error("Preset walk did not start at slot zero.");

  // A group that is still initializing is never reported as running.
  property p_no_power_while_busy;
    @(posedge ref_clk) disable iff (!rst_n)
      init_busy[0] |-> !group_powered[0];
  endproperty
  a_no_power_while_busy: assert property (p_no_power_while_busy)
    else $error("Group 0 reported running during init.");

  // Read data stand for one cycle only; otherwise the port shows zero.
  property p_rdata_idle_zero;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && !reg_rd) |=> (reg_rdata == 8'h00);
  endproperty
  a_rdata_idle_zero: assert property (p_rdata_idle_zero)
    else $error("Read data not zero outside a read.");
endmodule : egc_top
`default_nettype wire

// File: egc_top_tb.sv
// Purpose: Self-checking bench for the group control and tone interrupt queue block.
// Assumes: 50 MHz ref_clk; register strobes are one cycle; read data stand one cycle.
// Notes: The full two-frame init wait runs, since the top exposes no shorter count.
`default_nettype none
module egc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [10:0] reg_addr = 11'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tone_evt = 1'b0;
  logic [4:0] tone_chan = 5'h00;
  logic [31:0] rin_pcm = 32'h0;
  logic [7:0] reg_rdata;
  logic irq;
  logic [3:0] group_powered;
  logic [7:0] group_coding;
  logic [3:0] init_busy;
  logic [3:0] clear_we;
  logic [23:0] clear_addr;
  logic [31:0] rout_bypass;
  logic [3:0] bypass_en;
  int miscompares = 0;
  int num_checks = 0;
  int clr_cnt = 0;
  logic [63:0] clr_seen = 64'h0;
  logic [7:0] rd;

  egc_top u_egc_top (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .tone_evt(tone_evt),
    .tone_chan(tone_chan), .rin_pcm(rin_pcm), .reg_rdata(reg_rdata), .irq(irq),
    .group_powered(group_powered), .group_coding(group_coding), .init_busy(init_busy),
    .clear_we(clear_we), .clear_addr(clear_addr), .rout_bypass(rout_bypass),
    .bypass_en(bypass_en));

  // Free-running 20 ns clock.
  always #10 ref_clk = ~ref_clk;

  // Tallies the preset slots of group 0 so gaps or repeats show up.
  always @(posedge ref_clk) begin
    if (clear_we[0] === 1'b1) begin
      clr_cnt++;
      clr_seen[clear_addr[5:0]] = 1'b1;
    end
  end

  task automatic test_done();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %0h want %0h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic reg_write(input logic [10:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Data stand only in the cycle after the strobe, so they are sampled just after that edge.
  task automatic reg_read(input logic [10:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (init_busy[0] !== lvl && n < lim) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (init_busy[0] !== lvl) begin
      miscompares++;
      $display("mismatch at %0t: init busy wait ran out", $time);
      test_done();
    end
  endtask : wait_busy

  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    reg_read(egc_pkg::IRQ_QUEUE_ADDR, rd);
    chk(rd, 8'h00, "queue after reset");
    reg_read(egc_pkg::GROUP_CTRL_BASE, rd);
    chk(rd, egc_pkg::CTRL_RESET, "ctrl after reset");
    chk({bypass_en, group_powered}, 8'hF0, "powered down at reset");
    // Receive PCM must pass through while every group is down.
    @(posedge ref_clk);
    rin_pcm <= 32'hA5C3_1E77;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(rout_bypass, 32'hA5C3_1E77, "bypass data");
    // Every coding and law combination, one per group.
    reg_write(11'h400, 8'h08);
    reg_write(11'h401, 8'h0C);
    reg_write(11'h402, 8'h00);
    reg_write(11'h403, 8'h04);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(group_coding, 8'h0E, "coding per group");
    // Power-up of group 0 starts the preset and wipe sequence.
    reg_write(11'h400, 8'h09);
    @(posedge ref_clk);
    #1;
    chk(group_powered[0], 1'b0, "not on at power rise");
    wait_busy(1'b1, 8);
    chk(group_powered[0], 1'b0, "not on while initializing");
    // The host keeps off the per-channel registers until the two frames are over.
    wait_busy(1'b0, 13000);
    chk(clr_cnt, 64, "preset slot count");
    chk(clr_seen, {64{1'b1}}, "preset slot coverage");
    repeat (2) @(posedge ref_clk);
    #1;
    chk({bypass_en[0], group_powered[0]}, 2'b01, "group 0 running");
    chk(group_coding[1:0], 2'b10, "coding kept");
    // Init done is reported through the status register and the irq level.
    chk(irq, 1'b0, "irq masked");
    reg_write(egc_pkg::IRQ_MASK_ADDR, 8'h04);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(irq, 1'b1, "irq unmasked");
    reg_read(egc_pkg::IRQ_STATUS_ADDR, rd);
    chk(rd, 8'h04, "init done status");
    repeat (2) @(posedge ref_clk);
    #1;
    chk(irq, 1'b0, "irq after clear");
    // Two back-to-back tone events on channels 5 and 31, the top of the channel field's range.
    @(posedge ref_clk);
    tone_evt <= 1'b1;
    tone_chan <= 5'h05;
    @(posedge ref_clk);
    tone_chan <= 5'h1F;
    @(posedge ref_clk);
    tone_evt <= 1'b0;
    reg_write(egc_pkg::IRQ_QUEUE_ADDR, 8'h55);
    reg_read(egc_pkg::IRQ_QUEUE_ADDR, rd);
    chk(rd, 8'h85, "first queue entry");
    reg_read(egc_pkg::IRQ_QUEUE_ADDR, rd);
    chk(rd, 8'h9F, "second queue entry");
    reg_read(egc_pkg::IRQ_QUEUE_ADDR, rd);
    chk(rd, 8'h00, "queue drained");
    reg_read(egc_pkg::IRQ_STATUS_ADDR, rd);
    chk(rd, 8'h01, "tone status");
    reg_read(11'h7FF, rd);
    chk(rd, 8'h00, "unmapped read");
    // Seventeen events into sixteen entries: the last is dropped and flagged.
    for (int i = 0; i < 17; i++) begin
      @(posedge ref_clk);
      tone_evt <= 1'b1;
      tone_chan <= 5'(i);
    end
    @(posedge ref_clk);
    tone_evt <= 1'b0;
    reg_read(egc_pkg::IRQ_STATUS_ADDR, rd);
    chk(rd, 8'h03, "overflow status");
    for (int i = 0; i < 16; i++) begin
      reg_read(egc_pkg::IRQ_QUEUE_ADDR, rd);
      chk(rd, 8'h80 | 8'(i), "queued entry in order");
    end
    reg_read(egc_pkg::IRQ_QUEUE_ADDR, rd);
    chk(rd, 8'h00, "queue empty after overflow");
    // A write while the clock enable is low must be lost.
    @(posedge ref_clk);
    clk_en <= 1'b0;
    reg_write(11'h403, 8'h08);
    clk_en <= 1'b1;
    reg_read(11'h403, rd);
    chk(rd, 8'h04, "frozen write ignored");
    // Dropping power returns the group to bypass.
    reg_write(11'h400, 8'h08);
    repeat (2) @(posedge ref_clk);
    #1;
    chk({bypass_en[0], group_powered[0]}, 2'b10, "group 0 down");
    // A reset in mid-run empties a loaded queue and powers every group down.
    @(posedge ref_clk);
    tone_evt <= 1'b1;
    tone_chan <= 5'h0A;
    @(posedge ref_clk);
    tone_evt <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    reg_read(egc_pkg::IRQ_QUEUE_ADDR, rd);
    chk(rd, 8'h00, "queue after second reset");
    reg_read(11'h401, rd);
    chk(rd, egc_pkg::CTRL_RESET, "ctrl after second reset");
    chk(bypass_en, 4'hF, "bypass after second reset");
    test_done();
  end
endmodule : egc_top_tb
`default_nettype wire
